// ==== shared/atl_pkg.sv ====
/*
 * Constants and carrier types for the axis scaling and travel supervision block.
 * Assumes a 10 MHz clock and a position-loop tick pulse from the servo loop.
 */
// Summary of operation
// - Scaling held as exact integer ratio
// - Velocity passed through unscaled, already in units/s
// - Overtravel off frees switches as program inputs
// - Sample overtravel switches every 10 ms while on
// - Open switch forces velocity command to zero
// - Enable relay held until host drops request
// - Trip writes switch-specific fault code
// - In overtravel fault only acknowledged nudge is accepted
// - Output override bypasses overtravel checks
// - Drive-ready check only in analog mode
// - Drive must report ready within 1 s
// - Drive-ready loss while on gives C0h, stop
// - Positive motion wraps past high to low
// - Negative motion wraps past low to high
// - Target above upper bound refused with error
// - Follower master motion skips travel bounds
// - Constant-speed commands skip travel bounds
// - Target below lower bound refused with error
// - Upper bound beyond wrap bound clamped, 17h
// - One switch enables both bounds, reset off
package atl_pkg;

	localparam int unsigned CLK_HZ          = 10_000_000;
	localparam int unsigned OT_SAMPLE_MS    = 10;
	localparam int unsigned OT_SAMPLE_CYC   = CLK_HZ / 1000 * OT_SAMPLE_MS;
	localparam int unsigned READY_WAIT_MS   = 1000;
	localparam int unsigned READY_WAIT_CYC  = CLK_HZ / 1000 * READY_WAIT_MS;
	localparam int unsigned TIMER_W         = 24;

	localparam int unsigned POS_W           = 32;
	localparam int unsigned SCALE_W         = 16;
	localparam int unsigned ACC_W           = 64;

	localparam logic [7:0]  ERR_NONE        = 8'h00;
	localparam logic [7:0]  ERR_OT_POS      = 8'h31;
	localparam logic [7:0]  ERR_OT_NEG      = 8'h32;
	localparam logic [7:0]  ERR_BOUND_CLAMP = 8'h17;
	localparam logic [7:0]  ERR_DRIVE_READY = 8'hC0;
	localparam logic [7:0]  ERR_TRAVEL_HIGH = 8'h21;
	localparam logic [7:0]  ERR_TRAVEL_LOW  = 8'h22;

	localparam logic signed [31:0] HIGH_WRAP_RST = 32'sh007FFFFF;
	localparam logic signed [31:0] LOW_WRAP_RST  = 32'shFF800000;

	typedef enum logic [1:0] {
		ATL_MODE_ANALOG  = 2'h0,
		ATL_MODE_DIGITAL = 2'h1,
		ATL_MODE_AUX     = 2'h2
	} atl_mode_t;

	typedef enum logic [1:0] {
		ATL_PWR_OFF  = 2'h0,
		ATL_PWR_WAIT = 2'h1,
		ATL_PWR_ON   = 2'h3,
		ATL_PWR_TRIP = 2'h2
	} atl_pwr_t;

	typedef enum logic [1:0] {
		ATL_SRC_PROGRAM  = 2'h0,
		ATL_SRC_NUDGE    = 2'h1,
		ATL_SRC_FOLLOWER = 2'h2,
		ATL_SRC_SPEED    = 2'h3
	} atl_src_t;

	typedef struct packed {
		logic [15:0] user_units;
		logic [15:0] fb_counts;
		atl_mode_t   mode;
		logic        ot_check_en;
		logic        ready_check_en;
		logic        bounds_en;
		logic        follower_en;
		logic signed [31:0] high_wrap;
		logic signed [31:0] low_wrap;
		logic signed [31:0] upper_bound;
		logic signed [31:0] lower_bound;
	} atl_cfg_t;

	typedef struct packed {
		logic        valid;
		atl_src_t    src;
		logic signed [31:0] target;
	} atl_cmd_t;

endpackage : atl_pkg

// ==== verilog/atl_scale.sv ====
/*
 * Exact integer ratio conversion: value * num / den, signed.
 * Assumes operands stay stable across the cycle; result is registered.
 */
`timescale 1ns/1ns
module atl_scale (
	input  wire logic                clk_i,  // 10 MHz clock
	input  wire logic                rstn_i, // Async reset, active low
	input  wire logic signed [31:0]  val_i,  // Value to convert
	input  wire logic [15:0]         num_i,  // Ratio numerator
	input  wire logic [15:0]         den_i,  // Ratio denominator
	output logic signed [31:0]       res_o   // Registered quotient
);
	logic signed [63:0] prod;
	logic signed [63:0] quot;

	always_comb begin
		prod = 64'(val_i) * $signed({48'h0, num_i});
		// Zero denominator is illegal; hold zero rather than divide by it
		if (den_i == 16'h0000) begin
			quot = 64'sh0;
		end else begin
			quot = prod / $signed({48'h0, den_i});
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			res_o <= 32'sh0;
		end else begin
			res_o <= quot[31:0];
		end
	end
endmodule : atl_scale

// ==== verilog/atl_axis.sv ====
/*
 * Single-axis scaling, rotary wrap, software travel bounds, overtravel and
 * drive-ready supervision. Assumes tick_i is a one-cycle pulse from the
 * position loop on clk_i, and that switch and drive-ready pins are asynchronous.
 */
`timescale 1ns/1ns
module atl_axis (
	input  wire logic                 clk_i,            // 10 MHz clock
	input  wire logic                 rstn_i,           // Async reset, active low
	input  wire logic                 tick_i,           // Position-loop tick pulse
	input  atl_pkg::atl_cfg_t         cfg_i,            // Static configuration
	input  wire logic                 pwr_req_i,        // Host power-stage request
	input  wire logic                 ack_i,            // Host fault acknowledge
	input  wire logic                 nudge_i,          // Host manual nudge request
	input  wire logic                 override_i,       // Direct output override
	input  atl_pkg::atl_cmd_t         cmd_i,            // Move command with target
	input  wire logic signed [31:0]   fb_delta_i,       // Feedback counts this tick
	input  wire logic signed [31:0]   vel_cmd_i,        // Velocity request, units/s
	input  wire logic signed [31:0]   override_val_i,   // Override velocity value
	input  wire logic                 overtravel_switch_pos, // Positive switch, 0 = open
	input  wire logic                 overtravel_switch_neg, // Negative switch, 0 = open
	input  wire logic                 drive_ok_input,   // Drive ready pin, 0 = ready
	output logic signed [31:0]        position_o,       // Measured position, user units
	output logic signed [31:0]        vel_out_o,        // Servo velocity command
	output logic                      relay_o,          // Axis enable relay
	output logic                      pwr_on_o,         // Power-stage-on status
	output logic [7:0]                fault_o,          // Axis fault word
	output logic                      move_ok_o,        // Command accepted pulse
	output logic                      move_refused_o,   // Command refused pulse
	output logic [1:0]                program_flow_inputs, // Freed switch inputs
	output logic signed [31:0]        upper_eff_o       // Effective upper bound
);
	typedef struct packed {
		logic [1:0]        pos_sync;
		logic [1:0]        neg_sync;
		logic [1:0]        rdy_sync;
		logic [23:0]       ot_timer;
		logic [23:0]       rdy_timer;
		atl_pkg::atl_pwr_t pwr;
		logic              ot_fault;
		logic [7:0]        fault;
		logic signed [31:0] pos;
		logic signed [31:0] vel;
		logic              relay;
		logic              pwr_on;
		logic              move_ok;
		logic              move_refused;
		logic [1:0]        flow;
		logic signed [31:0] upper_eff;
	} atl_state_t;

	atl_state_t              st;
	atl_state_t              next_st;
	logic signed [31:0]      delta_uu;
	logic signed [31:0]      vel_uu;
	logic signed [32:0]      sum;
	logic signed [32:0]      modulus;
	logic                    pos_open;
	logic                    neg_open;
	logic                    ready_on;
	logic                    ready_used;
	logic                    bounds_apply;
	logic signed [31:0]      upper_use;
	logic                    ot_trip;

	// Feedback counts to user units over the exact ratio
	atl_scale u_pos_scale (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.val_i  (fb_delta_i),
		.num_i  (cfg_i.user_units),
		.den_i  (cfg_i.fb_counts),
		.res_o  (delta_uu)
	);

	// Velocity is already in user units per second; pass-through kept exact
	assign vel_uu = vel_cmd_i;

	always_comb begin
		next_st = st;
		next_st.pos_sync = {st.pos_sync[0], overtravel_switch_pos};
		next_st.neg_sync = {st.neg_sync[0], overtravel_switch_neg};
		next_st.rdy_sync = {st.rdy_sync[0], drive_ok_input};
		next_st.move_ok = 1'b0;
		next_st.move_refused = 1'b0;
		ot_trip = 1'b0;

		pos_open = ~st.pos_sync[1];
		neg_open = ~st.neg_sync[1];
		ready_on = ~st.rdy_sync[1];
		ready_used = cfg_i.ready_check_en && (cfg_i.mode == atl_pkg::ATL_MODE_ANALOG);

		next_st.flow = cfg_i.ot_check_en ? 2'h0 : {st.neg_sync[1], st.pos_sync[1]};

		// Upper bound may not pass the wrap bound
		upper_use = cfg_i.upper_bound;
		next_st.upper_eff = cfg_i.upper_bound;
		if (cfg_i.bounds_en && (cfg_i.upper_bound > cfg_i.high_wrap)) begin
			upper_use = cfg_i.high_wrap;
			next_st.upper_eff = cfg_i.high_wrap;
			if (st.fault == atl_pkg::ERR_NONE) begin
				next_st.fault = atl_pkg::ERR_BOUND_CLAMP;
			end
		end

		// Position wrap with carry of the excess
		sum = 33'(st.pos) + 33'(delta_uu);
		modulus = 33'(cfg_i.high_wrap) - 33'(cfg_i.low_wrap) + 33'sh1;
		if (tick_i) begin
			if (sum > 33'(cfg_i.high_wrap)) begin
				next_st.pos = 32'(sum - modulus);
			end else if (sum < 33'(cfg_i.low_wrap)) begin
				next_st.pos = 32'(sum + modulus);
			end else begin
				next_st.pos = sum[31:0];
			end
		end

		// Overtravel sampling every 10 ms while power stage is on
		if (cfg_i.ot_check_en && st.pwr == atl_pkg::ATL_PWR_ON) begin
			if (st.ot_timer == 24'(atl_pkg::OT_SAMPLE_CYC - 1)) begin
				next_st.ot_timer = 24'h000000;
				if (pos_open || neg_open) begin
					ot_trip = 1'b1;
					next_st.ot_fault = 1'b1;
					next_st.pwr = atl_pkg::ATL_PWR_TRIP;
					next_st.fault = pos_open ? atl_pkg::ERR_OT_POS
						: atl_pkg::ERR_OT_NEG;
				end
			end else begin
				next_st.ot_timer = st.ot_timer + 24'h000001;
			end
		end else begin
			next_st.ot_timer = 24'h000000;
		end

		// Power-stage sequencing and drive-ready supervision
		case (st.pwr)
			atl_pkg::ATL_PWR_OFF: begin
				next_st.relay = 1'b0;
				next_st.rdy_timer = 24'h000000;
				if (pwr_req_i) begin
					next_st.relay = 1'b1;
					next_st.pwr = ready_used ? atl_pkg::ATL_PWR_WAIT : atl_pkg::ATL_PWR_ON;
				end
			end
			atl_pkg::ATL_PWR_WAIT: begin
				if (!pwr_req_i) begin
					next_st.relay = 1'b0;
					next_st.pwr = atl_pkg::ATL_PWR_OFF;
				end else if (ready_on) begin
					next_st.pwr = atl_pkg::ATL_PWR_ON;
				end else if (st.rdy_timer == 24'(atl_pkg::READY_WAIT_CYC - 1)) begin
					next_st.fault = atl_pkg::ERR_DRIVE_READY;
					next_st.pwr = atl_pkg::ATL_PWR_TRIP;
				end else begin
					next_st.rdy_timer = st.rdy_timer + 24'h000001;
				end
			end
			atl_pkg::ATL_PWR_ON: begin
				if (!pwr_req_i) begin
					next_st.relay = 1'b0;
					next_st.pwr = atl_pkg::ATL_PWR_OFF;
				end else if (ready_used && !ready_on) begin
					next_st.fault = atl_pkg::ERR_DRIVE_READY;
					next_st.pwr = atl_pkg::ATL_PWR_TRIP;
				end
			end
			atl_pkg::ATL_PWR_TRIP: begin
				// Relay stays closed so the axis can be held and nudged off
				if (!pwr_req_i) begin
					next_st.relay = 1'b0;
					next_st.pwr = atl_pkg::ATL_PWR_OFF;
				end
			end
			default: begin
				next_st.pwr = atl_pkg::ATL_PWR_OFF;
			end
		endcase

		// Fault clears once acknowledged and the switches are closed again;
		// a fresh trip in the same cycle wins because ot_trip blocks the clear
		if (st.ot_fault && ack_i && !nudge_i && !pos_open && !neg_open && !ot_trip) begin
			next_st.ot_fault = 1'b0;
		end
		if (ack_i && !nudge_i && (next_st.ot_fault == 1'b0) && (st.fault != atl_pkg::ERR_NONE)
				&& (next_st.fault == st.fault)) begin
			next_st.fault = atl_pkg::ERR_NONE;
			if (st.pwr == atl_pkg::ATL_PWR_TRIP && pwr_req_i) begin
				next_st.pwr = atl_pkg::ATL_PWR_ON;
			end
		end

		// Command acceptance and software travel bounds
		bounds_apply = cfg_i.bounds_en
			&& (cmd_i.src != atl_pkg::ATL_SRC_SPEED)
			&& !(cfg_i.follower_en && cmd_i.src == atl_pkg::ATL_SRC_FOLLOWER);
		if (cmd_i.valid) begin
			if (st.ot_fault && !(cmd_i.src == atl_pkg::ATL_SRC_NUDGE && nudge_i && ack_i)) begin
				next_st.move_refused = 1'b1;
			end else if (bounds_apply && cmd_i.target > upper_use) begin
				next_st.move_refused = 1'b1;
				// An overtravel code outranks a travel error until acknowledged
				if (!next_st.ot_fault) begin
					next_st.fault = atl_pkg::ERR_TRAVEL_HIGH;
				end
			end else if (bounds_apply && cmd_i.target < cfg_i.lower_bound) begin
				next_st.move_refused = 1'b1;
				if (!next_st.ot_fault) begin
					next_st.fault = atl_pkg::ERR_TRAVEL_LOW;
				end
			end else begin
				next_st.move_ok = 1'b1;
			end
		end

		// Velocity command: override first, then stop on trip without a ramp
		if (override_i) begin
			next_st.vel = override_val_i;
		end else if (next_st.pwr != atl_pkg::ATL_PWR_ON || next_st.ot_fault) begin
			next_st.vel = 32'sh0;
		end else begin
			next_st.vel = vel_uu;
		end
		if (st.ot_fault && nudge_i && ack_i && !override_i) begin
			next_st.vel = vel_uu;
		end
		next_st.pwr_on = (next_st.pwr == atl_pkg::ATL_PWR_ON);
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st <= '{pos_sync: 2'h3, neg_sync: 2'h3, rdy_sync: 2'h3,
				pwr: atl_pkg::ATL_PWR_OFF, fault: atl_pkg::ERR_NONE,
				upper_eff: atl_pkg::HIGH_WRAP_RST, default: '0};
		end else begin
			st <= next_st;
		end
	end

	assign position_o          = st.pos;
	assign vel_out_o           = st.vel;
	assign relay_o             = st.relay;
	assign pwr_on_o            = st.pwr_on;
	assign fault_o             = st.fault;
	assign move_ok_o           = st.move_ok;
	assign move_refused_o      = st.move_refused;
	assign program_flow_inputs = st.flow;
	assign upper_eff_o         = st.upper_eff;
endmodule : atl_axis

// ==== testbench/atl_axis_assertions.sv ====
/* Port checker for atl_axis.
   Bound to every atl_axis instance; sees only its ports, one clock domain. */
`timescale 1ns/1ns
module atl_axis_assertions (
	input wire logic          clk_i,               // Clock
	input wire logic          rstn_i,              // Reset, active low
	input atl_pkg::atl_cfg_t  cfg_i,               // Configuration
	input wire logic          pwr_req_i,           // Power request
	input wire logic          nudge_i,             // Nudge
	input wire logic          override_i,          // Override
	input atl_pkg::atl_cmd_t  cmd_i,               // Command
	input wire logic          drive_ok_input,      // Drive ready pin
	input wire logic signed [31:0] vel_out_o,      // Velocity out
	input wire logic signed [31:0] upper_eff_o,    // Effective upper bound
	input wire logic          relay_o,             // Relay
	input wire logic          pwr_on_o,            // Power on
	input wire logic [7:0]    fault_o,             // Fault word
	input wire logic          move_ok_o,           // Accepted
	input wire logic          move_refused_o,      // Refused
	input wire logic [1:0]    program_flow_inputs  // Freed inputs
);
	logic ot_f;
	assign ot_f = fault_o == atl_pkg::ERR_OT_POS || fault_o == atl_pkg::ERR_OT_NEG;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	AST_VEL_STOP: assert property ((ot_f && !nudge_i && !override_i) [*2] |-> vel_out_o == 0)
		else $error("velocity not zero in overtravel");
	AST_RELAY_HOLD: assert property (relay_o && pwr_req_i |=> relay_o)
		else $error("relay opened while requested");
	AST_RELAY_DROP: assert property (!pwr_req_i |=> !relay_o)
		else $error("relay held without request");
	AST_CMD_ANSWER: assert property (cmd_i.valid |=> move_ok_o != move_refused_o)
		else $error("command not answered once");
	AST_OT_REFUSE: assert property (
		cmd_i.valid && ot_f && cmd_i.src != atl_pkg::ATL_SRC_NUDGE |=> move_refused_o)
		else $error("command taken in overtravel");
	AST_HIGH_REFUSE: assert property (
		cmd_i.valid && cfg_i.bounds_en && !ot_f &&
		cmd_i.src == atl_pkg::ATL_SRC_PROGRAM && cmd_i.target > upper_eff_o
		|=> move_refused_o && fault_o == atl_pkg::ERR_TRAVEL_HIGH)
		else $error("high target");
	AST_LOW_REFUSE: assert property (
		cmd_i.valid && cfg_i.bounds_en && !ot_f &&
		cmd_i.src == atl_pkg::ATL_SRC_PROGRAM && cmd_i.target < cfg_i.lower_bound
		|=> move_refused_o && fault_o == atl_pkg::ERR_TRAVEL_LOW)
		else $error("low target");
	AST_SPEED_FREE: assert property (
		cmd_i.valid && cmd_i.src == atl_pkg::ATL_SRC_SPEED && !ot_f |=> move_ok_o)
		else $error("speed command refused");
	AST_CLAMP: assert property (
		(cfg_i.bounds_en && (cfg_i.upper_bound > cfg_i.high_wrap)) [*2]
		|-> upper_eff_o == cfg_i.high_wrap)
		else $error("upper bound not clamped");
	AST_FLOW_ZERO: assert property (cfg_i.ot_check_en [*2] |-> program_flow_inputs == 2'h0)
		else $error("freed inputs shown while checking");
	AST_READY_LOSS: assert property (
		$rose(drive_ok_input) && pwr_on_o && cfg_i.ready_check_en &&
		cfg_i.mode == atl_pkg::ATL_MODE_ANALOG |-> ##[1:5] fault_o == atl_pkg::ERR_DRIVE_READY)
		else $error("drive ready loss not reported");
	AST_DIGITAL_ON: assert property (
		pwr_req_i && !relay_o && cfg_i.mode != atl_pkg::ATL_MODE_ANALOG |-> ##[1:2] pwr_on_o)
		else $error("power on delayed outside analog mode");
endmodule : atl_axis_assertions

bind atl_axis atl_axis_assertions chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .cfg_i(cfg_i),
	.pwr_req_i(pwr_req_i), .nudge_i(nudge_i), .override_i(override_i), .cmd_i(cmd_i),
	.drive_ok_input(drive_ok_input), .vel_out_o(vel_out_o), .upper_eff_o(upper_eff_o),
	.relay_o(relay_o), .pwr_on_o(pwr_on_o), .fault_o(fault_o), .move_ok_o(move_ok_o),
	.move_refused_o(move_refused_o), .program_flow_inputs(program_flow_inputs));

// ==== testbench/atl_drive_model.sv ====
/* Servo drive with its two overtravel switches.
   Assumes the bench opens switches and drops ready on purpose only. */
`timescale 1ns/1ns
module atl_drive_model #(
	parameter int READY_DLY = 20
) (
	input  wire logic clk_i,        // Clock
	input  wire logic rstn_i,       // Reset, active low
	input  wire logic relay_i,      // Enable relay from the axis
	input  wire logic open_pos_i,   // Open positive switch
	input  wire logic open_neg_i,   // Open negative switch
	input  wire logic ready_drop_i, // Force drive not ready
	output logic      sw_pos_o,     // Positive switch, 1 = closed
	output logic      sw_neg_o,     // Negative switch, 1 = closed
	output logic      ready_n_o     // Drive ready, 0 = ready
);
	int cnt;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			cnt <= 0;
		else if (!relay_i)
			cnt <= 0;
		else if (cnt < READY_DLY)
			cnt <= cnt + 1;
	end
	// Slow answer, still far inside the one second allowed
	assign ready_n_o = !(relay_i && cnt == READY_DLY && !ready_drop_i);
	assign sw_pos_o = !open_pos_i;
	assign sw_neg_o = !open_neg_i;
endmodule : atl_drive_model

// ==== testbench/atl_axis_test.sv ====
/* Self-checking bench for atl_axis.
   Uses atl_drive_model as far side; one overtravel sample takes up to 10 ms. */
`timescale 1ns/1ns
module atl_axis_test;
	logic clk_i = 1'b0, rstn_i = 1'b0, tick_i = 1'b0, pwr_req_i = 1'b0, ack_i = 1'b0;
	logic nudge_i = 1'b0, override_i = 1'b0, open_pos = 1'b0, open_neg = 1'b0, rdrop = 1'b0;
	atl_pkg::atl_cfg_t cfg_i;
	atl_pkg::atl_cmd_t cmd_i;
	atl_pkg::atl_src_t s;
	logic signed [31:0] fb_delta_i = 32'h0, vel_cmd_i = 32'h0, override_val_i = 32'h0;
	logic signed [31:0] position_o, vel_out_o, upper_eff_o, t, d, p;
	logic signed [31:0] tbl[6] = '{32'sh12C, 32'sh12D, 32'sh9, 32'sh1388, 32'sh9, 32'shA};
	logic signed [31:0] dl[5] = '{32'shC8, 32'sh9F, 32'sh1, -32'sh1, 32'sh3C};
	logic sw_pos, sw_neg, ready_n, relay_o, pwr_on_o, move_ok_o, move_refused_o;
	logic [7:0] fault_o;
	logic [1:0] program_flow_inputs;
	int fail_count = 0, total_checks = 0, cycles = 0, i;

	atl_axis dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .tick_i(tick_i), .cfg_i(cfg_i),
		.pwr_req_i(pwr_req_i), .ack_i(ack_i), .nudge_i(nudge_i), .override_i(override_i),
		.cmd_i(cmd_i), .fb_delta_i(fb_delta_i), .vel_cmd_i(vel_cmd_i),
		.override_val_i(override_val_i), .overtravel_switch_pos(sw_pos),
		.overtravel_switch_neg(sw_neg), .drive_ok_input(ready_n), .position_o(position_o),
		.vel_out_o(vel_out_o), .relay_o(relay_o), .pwr_on_o(pwr_on_o), .fault_o(fault_o),
		.move_ok_o(move_ok_o), .move_refused_o(move_refused_o),
		.program_flow_inputs(program_flow_inputs), .upper_eff_o(upper_eff_o));
	atl_drive_model drv_u (.clk_i(clk_i), .rstn_i(rstn_i), .relay_i(relay_o),
		.open_pos_i(open_pos), .open_neg_i(open_neg), .ready_drop_i(rdrop),
		.sw_pos_o(sw_pos), .sw_neg_o(sw_neg), .ready_n_o(ready_n));

	initial forever #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		// Overtravel sample alone may take 100,000 cycles
		if (cycles == 102000) begin
			fail_count++;
			complete_run();
		end
	end

	task complete_run();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : step
	task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk_word
	task send(input atl_pkg::atl_src_t sc, input logic signed [31:0] tg, input logic ok);
		cmd_i = '{1'b1, sc, tg};
		step(1);
		chk_word("move_ok", {31'h0, ok}, {31'h0, move_ok_o});
		chk_word("move_refused", {31'h0, !ok}, {31'h0, move_refused_o});
	endtask : send
	function automatic logic exp_ok(atl_pkg::atl_src_t sc, logic signed [31:0] tg, logic fol);
		return sc == atl_pkg::ATL_SRC_SPEED || (fol && sc == atl_pkg::ATL_SRC_FOLLOWER) ||
			(tg <= 32'sh12C && tg >= 32'shA);
	endfunction : exp_ok
	function automatic logic signed [31:0] wrap(logic signed [31:0] a, logic signed [31:0] b);
		a = a + b;
		if (a > 32'sh167)
			a = a - 32'sh168;
		else if (a < 0)
			a = a + 32'sh168;
		return a;
	endfunction : wrap

	initial begin
		cfg_i = '{16'h1, 16'h1, atl_pkg::ATL_MODE_DIGITAL, 1'b0, 1'b1, 1'b1, 1'b1,
			32'sh167, 32'sh0, 32'sh1F4, 32'shA};
		cmd_i = '0;
		void'($urandom(96));
		step(8);
		rstn_i = 1'b1;
		step(3);
		chk_word("upper_eff", 32'h167, upper_eff_o);
		chk_word("fault", 32'h17, {24'h0, fault_o});
		$display("clamp test done");
		cfg_i.upper_bound = 32'sh12C;
		step(3);
		for (i = 0; i < 26; i++) begin
			t = (i < 6) ? tbl[i] : int'($urandom_range(440)) - 40;
			s = atl_pkg::atl_src_t'((i < 6) ? i % 4 : $urandom_range(3));
			cfg_i.follower_en = (i < 16);
			send(s, t, exp_ok(s, t, i < 16));
		end
		cfg_i.bounds_en = 1'b0;
		step(2);
		send(atl_pkg::ATL_SRC_PROGRAM, 32'sh3E8, 1'b1);
		cmd_i.valid = 1'b0;
		$display("bounds test done");
		p = 32'sh0;
		for (i = 0; i < 14; i++) begin
			d = (i < 5) ? dl[i] : int'($urandom_range(718)) - 359;
			if (i == 13)
				cfg_i.fb_counts = 16'h4;
			fb_delta_i = (i == 13) ? 32'sh8 : d;
			step(2);
			tick_i = 1'b1;
			step(1);
			tick_i = 1'b0;
			step(3);
			p = wrap(p, (i == 13) ? 32'sh2 : d);
			chk_word("position", p, position_o);
		end
		open_pos = 1'b1;
		step(4);
		chk_word("flow_inputs", 32'h2, {30'h0, program_flow_inputs});
		open_pos = 1'b0;
		$display("wrap test done");
		rstn_i = 1'b0;
		cfg_i = '{16'h1, 16'h1, atl_pkg::ATL_MODE_DIGITAL, 1'b1, 1'b1, 1'b1, 1'b0,
			32'sh167, 32'sh0, 32'sh12C, 32'shA};
		step(2);
		rstn_i = 1'b1;
		pwr_req_i = 1'b1;
		vel_cmd_i = 32'sh64;
		step(3);
		chk_word("pwr_on", 32'h1, {31'h0, pwr_on_o});
		chk_word("vel_out", 32'h64, vel_out_o);
		open_neg = 1'b1;
		for (i = 0; i < 100100 && fault_o !== atl_pkg::ERR_OT_NEG; i++)
			step(1);
		step(2);
		chk_word("fault", 32'h32, {24'h0, fault_o});
		chk_word("vel_out", 32'h0, vel_out_o);
		chk_word("relay", 32'h1, {31'h0, relay_o});
		override_i = 1'b1;
		override_val_i = 32'sh4D;
		step(3);
		chk_word("vel_out", 32'h4D, vel_out_o);
		override_i = 1'b0;
		send(atl_pkg::ATL_SRC_PROGRAM, 32'sh14, 1'b0);
		nudge_i = 1'b1;
		ack_i = 1'b1;
		send(atl_pkg::ATL_SRC_NUDGE, 32'sh14, 1'b1);
		cmd_i.valid = 1'b0;
		nudge_i = 1'b0;
		ack_i = 1'b0;
		open_neg = 1'b0;
		step(5);
		chk_word("fault", 32'h32, {24'h0, fault_o});
		ack_i = 1'b1;
		step(3);
		ack_i = 1'b0;
		chk_word("fault", 32'h0, {24'h0, fault_o});
		pwr_req_i = 1'b0;
		step(2);
		chk_word("relay", 32'h0, {31'h0, relay_o});
		$display("overtravel test done");
		cfg_i.mode = atl_pkg::ATL_MODE_ANALOG;
		cfg_i.ot_check_en = 1'b0;
		pwr_req_i = 1'b1;
		step(5);
		chk_word("pwr_on", 32'h0, {31'h0, pwr_on_o});
		for (i = 0; i < 100 && pwr_on_o !== 1'b1; i++)
			step(1);
		chk_word("pwr_on", 32'h1, {31'h0, pwr_on_o});
		rdrop = 1'b1;
		step(6);
		chk_word("fault", 32'hC0, {24'h0, fault_o});
		chk_word("vel_out", 32'h0, vel_out_o);
		$display("drive ready test done");
		complete_run();
	end
endmodule : atl_axis_test
